//--- rtl/pgdt_pkg.sv
// Purpose: constants for the PCS GMII datapath timing block
// Assumes: one 125 MHz-rate datapath clock, fixed GMII attachment style
// Notes: latencies in clock cycles at the 1 Gbps rate
// Contract
// - Collision detect is transmit enable AND receive data valid.
// - Carrier sense always equals receive data valid.
// - Transmit rate adaptation and transmit FSM delays are fixed.
// - Transmit latency depends only on GMII attachment style.
// - Transmit FSM adds 3; rate adapt adds 9 separate-clock, 2 enable-style.
// - Receive FSM and receive rate adaptation delays are constant; the rx pipe here holds while the output buffer is full.
// - Receive FSM adds 6; rate adapt adds 8 separate-clock, 2 enable-style.
// - Compensation FIFO latency may vary per frame.
// - Compensation latency 24 to 34 cycles; at most 4 adds/drops per frame.
// - Compensation FIFO thresholds default to 16 low, 32 high.
// - Latency counted on frame start, in cycles at 1 Gbps.
package pgdt_pkg;
	localparam int TX_FSM_LAT      = 3;
	localparam int TX_RA_LAT_SEP   = 9;
	localparam int TX_RA_LAT_EN    = 2;
	localparam int RX_FSM_LAT      = 6;
	localparam int RX_RA_LAT_SEP   = 8;
	localparam int RX_RA_LAT_EN    = 2;
	localparam int CTC_DEPTH       = 64;
	localparam int CTC_AW          = 6;
	localparam int CTC_LOW_THR     = 16;
	localparam int CTC_HIGH_THR    = 32;
	localparam int CTC_MAX_SLIP    = 4;
	localparam int CTC_SLIP_W      = 3;
	localparam int CTC_PRIME_LEVEL = 24;
	localparam int DATA_W          = 10;
	localparam int BUF_DEPTH       = 2;
	localparam logic [7:0] IDLE_CODE = 8'hBC;
	localparam logic [7:0] SFD_CODE  = 8'hD5;
	typedef enum logic {
		PGDT_STYLE_SEP,
		PGDT_STYLE_EN
	} pgdt_style_type;
endpackage : pgdt_pkg

//--- rtl/pgdt_buf_if.sv
`timescale 1ns/10ps
// Purpose: handshake carrier for the two-entry output buffer
// Assumes: single clock domain
// Notes: word is {err, dv, data}
interface pgdt_buf_if;
	logic                           in_valid;
	logic                           in_ready;
	logic [pgdt_pkg::DATA_W-1:0]    in_word;
	logic                           out_valid;
	logic                           out_ready;
	logic [pgdt_pkg::DATA_W-1:0]    out_word;
	modport owner (
		output in_valid,
		input  in_ready,
		output in_word,
		input  out_valid,
		output out_ready,
		input  out_word
	);
	modport buffer (
		input  in_valid,
		output in_ready,
		input  in_word,
		output out_valid,
		input  out_ready,
		output out_word
	);
endinterface : pgdt_buf_if

//--- rtl/pgdt_skid_buf.sv
`timescale 1ns/10ps
// Purpose: two-entry buffer so a receiver stall drops no word
// Assumes: synchronous active-low reset
// Notes: ready depends only on occupancy, never on out_ready
module pgdt_skid_buf (
	input  wire logic  clk,
	input  wire logic  rst_n,
	pgdt_buf_if.buffer bif
);
	typedef struct packed {
		logic [pgdt_pkg::BUF_DEPTH-1:0][pgdt_pkg::DATA_W-1:0] mem;
		logic                                              rd_ptr;
		logic                                              wr_ptr;
		logic [1:0]                                        count;
	} pgdt_buf_state_type;

	pgdt_buf_state_type st_reg;
	pgdt_buf_state_type st_next;
	logic               push;
	logic               pop;

	assign bif.in_ready  = (st_reg.count != 2'h2);
	assign bif.out_valid = (st_reg.count != 2'h0);
	assign bif.out_word  = st_reg.mem[st_reg.rd_ptr];
	assign push = bif.in_valid && bif.in_ready;
	assign pop  = bif.out_valid && bif.out_ready;

	always_comb begin
		st_next = st_reg;
		if (push) begin
			st_next.mem[st_reg.wr_ptr] = bif.in_word;
			st_next.wr_ptr = ~st_reg.wr_ptr;
		end
		if (pop) begin
			st_next.rd_ptr = ~st_reg.rd_ptr;
		end
		st_next.count = st_reg.count + 2'(push) - 2'(pop);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	buf_no_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
		st_reg.count <= 2'h2)
		else $error("buffer overfilled");
	buf_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		bif.out_valid && !bif.out_ready |=> bif.out_valid
			&& $stable(bif.out_word))
		else $error("buffered word lost during stall");
endmodule : pgdt_skid_buf

//--- rtl/pgdt_datapath.sv
`timescale 1ns/10ps
// Purpose: GMII status outputs, fixed tx/rx pipelines, rx compensation FIFO
// Assumes: one clock; code groups as bytes, idle marked by IDLE_CODE
// Notes: attachment style is a parameter since it fixes pipeline depth
module pgdt_datapath #(
	parameter pgdt_pkg::pgdt_style_type STYLE = pgdt_pkg::PGDT_STYLE_SEP
) (
	input  wire logic       CLK_SYS,
	input  wire logic       RST_N,
	input  wire logic       TX_EN,
	input  wire logic       TX_ER,
	input  wire logic [7:0] TXD,
	output logic            TX_CG_EN,
	output logic            TX_CG_ER,
	output logic [7:0]      TX_CG,
	input  wire logic       RX_CG_VALID,
	input  wire logic [7:0] RX_CG,
	input  wire logic       RX_CG_DV,
	input  wire logic       RX_CG_ER,
	output logic            RX_DV,
	output logic            RX_ER,
	output logic [7:0]      RXD,
	output logic            RX_OUT_VALID,
	input  wire logic       RX_OUT_READY,
	output logic            COL,
	output logic            CRS,
	output logic            CTC_INSERT,
	output logic            CTC_DELETE,
	output logic [5:0]      CTC_LEVEL
);
	// Fixed depths: style is the only knob, nothing frame-dependent
	localparam int TX_LAT = pgdt_pkg::TX_FSM_LAT +
		((STYLE == pgdt_pkg::PGDT_STYLE_SEP) ?
		pgdt_pkg::TX_RA_LAT_SEP : pgdt_pkg::TX_RA_LAT_EN);
	localparam int RX_LAT = pgdt_pkg::RX_FSM_LAT +
		((STYLE == pgdt_pkg::PGDT_STYLE_SEP) ?
		pgdt_pkg::RX_RA_LAT_SEP : pgdt_pkg::RX_RA_LAT_EN);
	localparam int DW = pgdt_pkg::DATA_W;
	localparam int AW = pgdt_pkg::CTC_AW;

	typedef enum logic [1:0] {
		CTC_PRIME,
		CTC_RUN
	} pgdt_ctc_mode_type;

	typedef struct packed {
		logic [TX_LAT-1:0][DW-1:0]              tx_pipe;
		logic [RX_LAT-1:0][DW-1:0]              rx_pipe;
		logic [pgdt_pkg::CTC_DEPTH-1:0][DW-1:0] fifo;
		logic [AW-1:0]                          wr_ptr;
		logic [AW-1:0]                          rd_ptr;
		logic [AW:0]                            level;
		pgdt_ctc_mode_type                      mode;
		logic [pgdt_pkg::CTC_SLIP_W-1:0]        slips;
		logic                                   ins;
		logic                                   del;
	} pgdt_state_type;

	pgdt_state_type st_reg;
	pgdt_state_type st_next;
	pgdt_buf_if     bif ();

	logic [DW-1:0] in_word;
	logic [DW-1:0] head_word;
	logic          head_idle;
	logic          wr_en;
	logic          rd_en;
	logic          do_ins;
	logic          do_del;
	logic          slip_ok;

	assign in_word   = {RX_CG_ER, RX_CG_DV, RX_CG};
	assign head_word = st_reg.fifo[st_reg.rd_ptr];
	assign head_idle = !head_word[8] && head_word[7:0] == pgdt_pkg::IDLE_CODE;
	assign slip_ok   = st_reg.slips < pgdt_pkg::CTC_MAX_SLIP;

	always_comb begin
		// Slips only between frames so frame bytes never move
		do_ins = 1'b0;
		do_del = 1'b0;
		wr_en  = 1'b0;
		rd_en  = 1'b0;
		if (st_reg.mode == CTC_RUN && bif.in_ready) begin
			rd_en = 1'b1;
			if (head_idle && slip_ok &&
				st_reg.level < (AW+1)'(pgdt_pkg::CTC_LOW_THR)) begin
				do_ins = 1'b1;
				rd_en  = 1'b0;
			end
		end
		if (RX_CG_VALID) begin
			wr_en = 1'b1;
			// Drop a fresh idle rather than a stored one to keep order
			if (!RX_CG_DV && RX_CG == pgdt_pkg::IDLE_CODE && slip_ok &&
				st_reg.level > (AW+1)'(pgdt_pkg::CTC_HIGH_THR)) begin
				do_del = 1'b1;
				wr_en  = 1'b0;
			end
		end
		if (st_reg.level == (AW+1)'(pgdt_pkg::CTC_DEPTH)) begin
			wr_en = 1'b0;
		end
		if (st_reg.level == '0) begin
			rd_en = 1'b0;
		end
	end

	always_comb begin
		st_next = st_reg;
		// Tx pipe is a pure shift register: delay fixed regardless of gap
		st_next.tx_pipe = {st_reg.tx_pipe[TX_LAT-2:0], {TX_ER, TX_EN, TXD}};
		st_next.rx_pipe = st_reg.rx_pipe;
		st_next.ins = do_ins;
		st_next.del = do_del;
		if (wr_en) begin
			st_next.fifo[st_reg.wr_ptr] = in_word;
			st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
		end
		if (rd_en) begin
			st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
		end
		st_next.level = st_reg.level + (AW+1)'(wr_en) - (AW+1)'(rd_en);
		if (st_reg.mode == CTC_PRIME &&
			st_reg.level >= (AW+1)'(pgdt_pkg::CTC_PRIME_LEVEL)) begin
			st_next.mode = CTC_RUN;
		end
		if (wr_en && in_word[8] && in_word[7:0] == pgdt_pkg::SFD_CODE) begin
			st_next.slips = '0;
		end else if ((do_ins || do_del) && slip_ok) begin
			st_next.slips = st_reg.slips + 1'b1;
		end
		// Rx pipe advances only when the buffer can take its tail word
		if (bif.in_ready) begin
			if (rd_en) begin
				st_next.rx_pipe = {st_reg.rx_pipe[RX_LAT-2:0], head_word};
			end else if (do_ins) begin
				st_next.rx_pipe = {st_reg.rx_pipe[RX_LAT-2:0],
					{2'b00, pgdt_pkg::IDLE_CODE}};
			end else begin
				st_next.rx_pipe = {st_reg.rx_pipe[RX_LAT-2:0],
					{2'b00, pgdt_pkg::IDLE_CODE}};
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bif.in_valid  = 1'b1;
	assign bif.in_word   = st_reg.rx_pipe[RX_LAT-1];
	assign bif.out_ready = RX_OUT_READY;

	pgdt_skid_buf u_buf (
		.clk   (CLK_SYS),
		.rst_n (RST_N),
		.bif   (bif)
	);

	assign TX_CG    = st_reg.tx_pipe[TX_LAT-1][7:0];
	assign TX_CG_EN = st_reg.tx_pipe[TX_LAT-1][8];
	assign TX_CG_ER = st_reg.tx_pipe[TX_LAT-1][9];
	assign RXD      = bif.out_word[7:0];
	assign RX_DV    = bif.out_valid && bif.out_word[8];
	assign RX_ER    = bif.out_valid && bif.out_word[9];
	assign RX_OUT_VALID = bif.out_valid;
	assign COL = TX_EN && RX_DV;
	assign CRS = RX_DV;
	assign CTC_INSERT = st_reg.ins;
	assign CTC_DELETE = st_reg.del;
	assign CTC_LEVEL  = st_reg.level[AW-1:0];

	tx_fixed_delay_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		##TX_LAT TX_CG_EN == $past(TX_EN, TX_LAT))
		else $error("transmit delay not fixed");
	col_and_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		COL == (TX_EN && RX_DV))
		else $error("collision not AND of enable and valid");
	crs_equal_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CRS == RX_DV)
		else $error("carrier sense differs from valid");
	slip_bound_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		st_reg.slips <= 3'(pgdt_pkg::CTC_MAX_SLIP))
		else $error("too many slips in one frame");
	ins_low_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CTC_INSERT |->
			$past(st_reg.level) < (AW+1)'(pgdt_pkg::CTC_LOW_THR))
		else $error("insert without low fill");
	del_high_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		CTC_DELETE |->
			$past(st_reg.level) > (AW+1)'(pgdt_pkg::CTC_HIGH_THR))
		else $error("delete without high fill");
	no_slip_frame_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		do_ins |-> !head_word[8])
		else $error("idle inserted inside a frame");
	rx_pipe_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		bif.in_ready && rd_en |=> st_reg.rx_pipe[0] == $past(head_word))
		else $error("receive pipe entry mismatch");
	ins_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
		CTC_INSERT);
	del_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
		CTC_DELETE);
	col_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N) COL);
	stall_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
		RX_OUT_VALID && !RX_OUT_READY ##1 RX_OUT_VALID && !RX_OUT_READY);
endmodule : pgdt_datapath

//--- tb/pgdt_mac_model.sv
// Purpose: receiving MAC model behind the receive buffer
// Assumes: ready moves only at the falling edge
// Notes: mode 0 always ready, 1 every other cycle, 2 stalled
`timescale 1ns/10ps
module pgdt_mac_model (
	input  wire logic       clk,
	input  wire logic [1:0] mode,
	output logic            ready
);
	logic toggle_reg;
	initial begin
		toggle_reg = 1'b0;
		ready = 1'b0;
	end
	always @(negedge clk) begin
		toggle_reg <= ~toggle_reg;
		ready      <= (mode == 2'h0) | ((mode == 2'h1) & toggle_reg);
	end
endmodule : pgdt_mac_model

//--- tb/tb_pcs_gmii_datapath_timing.sv
// Purpose: self-checking bench for the datapath timing block
// Assumes: separate-clock style, so tx latency 12
// Notes: sender stays put between bytes only as long as it strobes
`timescale 1ns/10ps
module tb_pcs_gmii_datapath_timing;
	logic       clk, rst_n, tx_en, tx_er, cg_v, cg_dv, cg_er;
	logic [7:0] txd, cg, tx_cg, rxd, rxd_q;
	logic       tx_cg_en, tx_cg_er, rx_dv, rx_er, o_v, o_r, col, crs;
	logic       ins, del, stall_q;
	logic [5:0] level;
	logic [1:0] mode;
	logic [7:0] exp_q[$];
	logic [7:0] got_q[$];
	int         n_errors, compares, n_ins, n_del, cyc, t_out;
	pgdt_datapath i_pgdt_datapath (.CLK_SYS(clk), .RST_N(rst_n),
		.TX_EN(tx_en), .TX_ER(tx_er), .TXD(txd), .TX_CG_EN(tx_cg_en),
		.TX_CG_ER(tx_cg_er), .TX_CG(tx_cg), .RX_CG_VALID(cg_v), .RX_CG(cg),
		.RX_CG_DV(cg_dv), .RX_CG_ER(cg_er), .RX_DV(rx_dv), .RX_ER(rx_er),
		.RXD(rxd), .RX_OUT_VALID(o_v), .RX_OUT_READY(o_r), .COL(col),
		.CRS(crs), .CTC_INSERT(ins), .CTC_DELETE(del), .CTC_LEVEL(level));
	pgdt_mac_model i_pgdt_mac_model (.clk(clk), .mode(mode), .ready(o_r));
	task wrap_up;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	task check_bit(input logic g, input logic e, input string m);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : check_bit
	task check_int(input int g, input int lo, input int hi, input string m);
		compares++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("wrong value at %0t: %s %0d", $time, m, g);
		end
	endtask : check_int
	task put(input logic [7:0] b, input logic dv, input int every);
		@(negedge clk) {cg_v, cg, cg_dv} = {1'b1, b, dv};
		repeat (every - 1) @(negedge clk) {cg_v, cg} = {1'b0, ~b};
	endtask : put
	task frame(input int idles, input int len, input int every,
		input logic [1:0] m, output int lat, output int del_pre,
		output int slip);
		int t_in;
		exp_q = {};
		got_q = {};
		n_ins = 0;
		n_del = 0;
		t_out = 0;
		mode = m;
		repeat (idles) put(pgdt_pkg::IDLE_CODE, 1'b0, every);
		// Slip window runs from frame start to end of gap; the drain after
		// it empties the FIFO and may insert idles on its own
		del_pre = n_del;
		slip = n_ins + n_del;
		t_in = cyc + 1;
		put(pgdt_pkg::SFD_CODE, 1'b1, every);
		exp_q.push_back(pgdt_pkg::SFD_CODE);
		tx_en = 1'b1;
		for (int i = 1; i <= len; i++) begin
			put(8'(i), 1'b1, every);
			exp_q.push_back(8'(i));
		end
		tx_en = 1'b0;
		repeat (12) put(pgdt_pkg::IDLE_CODE, 1'b0, every);
		del_pre = n_del - del_pre;
		slip = n_ins + n_del - slip;
		@(negedge clk) cg_v = 1'b0;
		mode = 2'h0;
		repeat (120) @(negedge clk);
		lat = t_out - t_in;
		check_int(got_q.size(), exp_q.size(), exp_q.size(), "len");
		foreach (exp_q[i])
			check_bit(got_q[i] === exp_q[i], 1'b1, "rx byte");
	endtask : frame
	task test_tx;
		int k;
		for (int p = 0; p < 2; p++) begin
			@(negedge clk) {tx_en, tx_er, txd} = {1'b1, p[0], 8'hA5 ^ 8'(p)};
			@(negedge clk) {tx_en, tx_er} = 2'b00;
			k = 1;
			while (!tx_cg_en && k < 30) begin
				@(posedge clk) #1;
				k++;
			end
			check_int(k, 12, 12, "tx latency");
			check_bit(tx_cg_er, p[0], "tx err");
			check_bit(tx_cg === (8'hA5 ^ 8'(p)), 1'b1, "tx byte");
			repeat (p + 3) @(negedge clk);
		end
	endtask : test_tx
	task test_rx;
		int lat, dp, sl;
		frame(30, 20, 1, 2'h0, lat, dp, sl);
		check_int(lat, 38, 51, "rx latency");
		check_int(sl, 0, 0, "slip at equal rate");
		frame(80, 16, 1, 2'h1, lat, dp, sl);
		check_int(dp, 4, 4, "deletes per frame");
		frame(4, 8, 1, 2'h2, lat, dp, sl);
		frame(30, 40, 2, 2'h0, lat, dp, sl);
		check_int(n_ins, 1, 1000, "idle inserts");
	endtask : test_rx
	always @(posedge clk) begin
		cyc++;
		if (rst_n && o_v && o_r && rx_dv) begin
			if (rxd === pgdt_pkg::SFD_CODE)
				t_out = cyc;
			got_q.push_back(rxd);
		end
		if (stall_q)
			check_bit(rxd === rxd_q, 1'b1, "held word");
		stall_q = rst_n & o_v & ~o_r;
		rxd_q = rxd;
		n_ins += int'(ins);
		n_del += int'(del);
		#5 if (rst_n) begin
			check_bit(col, tx_en & rx_dv, "collision");
			check_bit(crs, rx_dv, "carrier");
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#400000;
		n_errors++;
		wrap_up();
	end
	initial begin
		{rst_n, tx_en, tx_er, txd, cg_v, cg, cg_dv, cg_er} = '0;
		{mode, stall_q, rxd_q, cyc, t_out} = '0;
		repeat (5) @(negedge clk);
		rst_n = 1'b1;
		test_tx();
		test_rx();
		wrap_up();
	end
endmodule : tb_pcs_gmii_datapath_timing
